// *** hdl/remote_receiver.sv ***
// Remote control pulse receiver with Avalon-MM register slave
//
// How it works
// - Level change accepted after N equal filtered samples
// - Leader checked by low-width and cycle windows
// - Zero max low width: cycle window only
// - Zero max cycle: leaderless, no leader interrupt
// - Leader interrupt when its enable is set
// - Threshold mode: period at/above low threshold is one
// - Falling-edge interrupt per data-phase fall when enabled
// - Earliest enabled completion condition ends reception
// - Bit-cycle timeout ends frame, sets max flag
// - Nonzero expected counts must match at timeout
// - Excess low after falling edge ends frame
// - Enable then wait for leader before data
// - Clearing enable stops at once, drops data
// - Leader-optional: short low starts data directly
// - Same decode and completion with or without leader
// - Invert bit flips input polarity
// - Phase mode classes 1T, 1.5T, 2T by thresholds
// - Phase bits from pattern and previous bit
// - Decoded bits stored in three buffers
// - Completion interrupt, then wait for next leader
// - Expected counts 7 bits, all zero means none
// - Clock select: low-frequency tick or timer tick
// - New frame overwrites unread buffers
`timescale 1ns/1ps
`include "remote_receiver_cfg.svh"

module remote_receiver (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Avalon-MM slave
  input wire remote_receiver_pkg::avalon_req_t avs_req_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Sampling ticks and remote input
  input wire logic lf_tick_i,
  input wire logic timer_output_clock_i,
  input wire logic remote_rx_i,
  // Interrupt
  output logic irq_o
);
  import remote_receiver_pkg::*;

  rx_state_all_t s_q;
  rx_state_all_t s_d;

  // Next-state logic for bus, filter, framing and decode
  always_comb begin
    logic tick;
    logic new_filt;
    logic fall;
    logic [4:0] cnt_inc;
    logic [1:0] nbits;
    logic bit0;
    logic bit1;
    logic any_end;
    logic cnt_ok;
    logic finish;
    logic timeout;
    logic excess;
    logic bus_ack;
    rx_flags_t clr;
    rx_flags_t set;
    tick = 1'b0;
    new_filt = 1'b0;
    fall = 1'b0;
    cnt_inc = 5'h00;
    nbits = 2'h0;
    bit0 = 1'b0;
    bit1 = 1'b0;
    any_end = 1'b0;
    cnt_ok = 1'b0;
    finish = 1'b0;
    timeout = 1'b0;
    excess = 1'b0;
    bus_ack = 1'b0;
    clr = '0;
    set = '0;
    s_d = s_q;

    // Read data are latched one cycle ahead of the answer,
    // so the master must hold its request through it
    // Bus handshake: one wait cycle, then answer
    bus_ack = (avs_req_i.read | avs_req_i.write) & ~s_q.waitreq;
    if (bus_ack) begin
      s_d.waitreq = 1'b1;
    end else if (avs_req_i.read | avs_req_i.write) begin
      s_d.waitreq = 1'b0;
      s_d.rdata = 32'h0000_0000;
      if (avs_req_i.address == `OFS_ENABLE) begin
        s_d.rdata[`EN_RX_BIT] = s_q.cfg.receive_enable_bit;
        s_d.rdata[`EN_CLKSEL_BIT] = s_q.cfg.sample_clock_select;
      end else if (avs_req_i.address == `OFS_LEADER) begin
        s_d.rdata = {s_q.cfg.leader_cycle_max, s_q.cfg.leader_cycle_min,
                     s_q.cfg.leader_low_max, s_q.cfg.leader_low_min};
      end else if (avs_req_i.address == `OFS_RXCTRL) begin
        s_d.rdata[7:0] = s_q.cfg.max_bit_cycle_limit;
        s_d.rdata[15:8] = s_q.cfg.excess_low_limit;
        s_d.rdata[`RC_LIEN_BIT] = s_q.cfg.leader_irq_enable;
        s_d.rdata[`RC_EDIEN_BIT] = s_q.cfg.falling_edge_irq_enable;
        s_d.rdata[`RC_LDOPT_BIT] = s_q.cfg.leader_optional;
        s_d.rdata[`RC_PHASE_BIT] = s_q.cfg.phase_method_enable;
      end else if (avs_req_i.address == `OFS_THRESH) begin
        s_d.rdata[6:0] = s_q.cfg.thresh_low;
        s_d.rdata[14:8] = s_q.cfg.thresh_high;
      end else if (avs_req_i.address == `OFS_INPUT) begin
        s_d.rdata[3:0] = s_q.cfg.noise_filter_cycles;
        s_d.rdata[`IN_INVERT_BIT] = s_q.cfg.input_invert;
      end else if (avs_req_i.address == `OFS_ENDBITS) begin
        s_d.rdata[6:0] = s_q.cfg.expected_bits_a;
        s_d.rdata[14:8] = s_q.cfg.expected_bits_b;
        s_d.rdata[22:16] = s_q.cfg.expected_bits_c;
      end else if (avs_req_i.address == `OFS_STATUS) begin
        s_d.rdata[6:0] = s_q.last_cnt;
        s_d.rdata[`ST_LDR_DET_BIT] = s_q.flags.leader_det;
        s_d.rdata[`ST_LDR_IRQ_BIT] = s_q.flags.leader_irq;
        s_d.rdata[`ST_EDGE_IRQ_BIT] = s_q.flags.edge_irq;
        s_d.rdata[`ST_MAX_BIT] = s_q.flags.max_cycle_flag;
        s_d.rdata[`ST_LOW_BIT] = s_q.flags.excess_low_flag;
        s_d.rdata[`ST_DONE_BIT] = s_q.flags.done;
        s_d.rdata[`ST_BUSY_BIT] = s_q.st == ST_DATA;
      end else if (avs_req_i.address == `OFS_BUF_A) begin
        s_d.rdata = s_q.rx_buf[31:0];
      end else if (avs_req_i.address == `OFS_BUF_B) begin
        s_d.rdata = s_q.rx_buf[63:32];
      end else if (avs_req_i.address == `OFS_BUF_C) begin
        s_d.rdata[7:0] = s_q.rx_buf[71:64];
      end
    end

    // Writes leave the last read data standing
    if (!avs_req_i.read) begin
      s_d.rdata = s_q.rdata;
    end

    // Register writes take effect at the completing edge
    if (bus_ack && avs_req_i.write) begin
      if (avs_req_i.address == `OFS_ENABLE) begin
        s_d.cfg.receive_enable_bit = avs_req_i.writedata[`EN_RX_BIT];
        s_d.cfg.sample_clock_select = avs_req_i.writedata[`EN_CLKSEL_BIT];
      end else if (avs_req_i.address == `OFS_LEADER) begin
        s_d.cfg.leader_cycle_max = avs_req_i.writedata[31:24];
        s_d.cfg.leader_cycle_min = avs_req_i.writedata[23:16];
        s_d.cfg.leader_low_max = avs_req_i.writedata[15:8];
        s_d.cfg.leader_low_min = avs_req_i.writedata[7:0];
      end else if (avs_req_i.address == `OFS_RXCTRL) begin
        s_d.cfg.max_bit_cycle_limit = avs_req_i.writedata[7:0];
        s_d.cfg.excess_low_limit = avs_req_i.writedata[15:8];
        s_d.cfg.leader_irq_enable = avs_req_i.writedata[`RC_LIEN_BIT];
        s_d.cfg.falling_edge_irq_enable =
          avs_req_i.writedata[`RC_EDIEN_BIT];
        s_d.cfg.leader_optional = avs_req_i.writedata[`RC_LDOPT_BIT];
        s_d.cfg.phase_method_enable = avs_req_i.writedata[`RC_PHASE_BIT];
      end else if (avs_req_i.address == `OFS_THRESH) begin
        s_d.cfg.thresh_low = avs_req_i.writedata[6:0];
        s_d.cfg.thresh_high = avs_req_i.writedata[14:8];
      end else if (avs_req_i.address == `OFS_INPUT) begin
        s_d.cfg.noise_filter_cycles = avs_req_i.writedata[3:0];
        s_d.cfg.input_invert = avs_req_i.writedata[`IN_INVERT_BIT];
      end else if (avs_req_i.address == `OFS_ENDBITS) begin
        s_d.cfg.expected_bits_a = avs_req_i.writedata[6:0];
        s_d.cfg.expected_bits_b = avs_req_i.writedata[14:8];
        s_d.cfg.expected_bits_c = avs_req_i.writedata[22:16];
      end else if (avs_req_i.address == `OFS_STATUS) begin
        clr.leader_det = avs_req_i.writedata[`ST_LDR_DET_BIT];
        clr.leader_irq = avs_req_i.writedata[`ST_LDR_IRQ_BIT];
        clr.edge_irq = avs_req_i.writedata[`ST_EDGE_IRQ_BIT];
        clr.max_cycle_flag = avs_req_i.writedata[`ST_MAX_BIT];
        clr.excess_low_flag = avs_req_i.writedata[`ST_LOW_BIT];
        clr.done = avs_req_i.writedata[`ST_DONE_BIT];
      end
    end

    // Sample tick source and noise filter
    // Filter looks at the previous sample, so both edges are
    // delayed alike and widths are preserved
    tick = s_q.cfg.sample_clock_select ? timer_output_clock_i
                                       : lf_tick_i;
    new_filt = s_q.filt;
    if (tick) begin
      s_d.raw = remote_rx_i ^ s_q.cfg.input_invert;
      cnt_inc = {1'b0, s_q.flt_cnt} + 5'h01;
      if (s_q.raw == s_q.filt) begin
        s_d.flt_cnt = 4'h0;
      end else if (cnt_inc >= {1'b0, s_q.cfg.noise_filter_cycles}) begin
        new_filt = s_q.raw;
        s_d.flt_cnt = 4'h0;
      end else begin
        s_d.flt_cnt = cnt_inc[3:0];
      end
    end
    s_d.filt = new_filt;
    fall = tick & s_q.filt & ~new_filt;

    // Interval counters in sample periods, saturating
    // Counting from one on a fall lets the next fall see
    // the full period in ticks
    if (fall) begin
      s_d.cyc_cnt = 8'h01;
      s_d.low_cnt = 8'h01;
    end else if (tick) begin
      if (s_q.cyc_cnt != `CNT_SAT) begin
        s_d.cyc_cnt = s_q.cyc_cnt + 8'h01;
      end
      if (!new_filt && s_q.low_cnt != `CNT_SAT) begin
        s_d.low_cnt = s_q.low_cnt + 8'h01;
      end
    end

    // Frame sequencing
    // A bad leader raises no flag; it only restarts the
    // search for the next leader low
    case (s_q.st)
      ST_IDLE: begin
        if (s_q.cfg.receive_enable_bit) begin
          s_d.st = ST_WAIT_LDR;
        end
      end
      ST_WAIT_LDR: begin
        if (fall) begin
          s_d.shreg = '0;
          s_d.bit_cnt = 7'h00;
          s_d.prev_bit = 1'b1;
          if (s_q.cfg.leader_cycle_max == 8'h00) begin
            s_d.st = ST_DATA;
          end else begin
            s_d.st = ST_LDR_LOW;
          end
        end
      end
      ST_LDR_LOW: begin
        if (tick && new_filt) begin
          // A zero low maximum skips the low window check
          if (s_q.cfg.leader_low_max == 8'h00) begin
            s_d.st = ST_LDR_HIGH;
          end else if (s_q.low_cnt >= s_q.cfg.leader_low_min &&
                       s_q.low_cnt <= s_q.cfg.leader_low_max) begin
            s_d.st = ST_LDR_HIGH;
          end else if (s_q.cfg.leader_optional &&
                       s_q.low_cnt < s_q.cfg.leader_low_max) begin
            s_d.st = ST_DATA;
          end else begin
            s_d.st = ST_WAIT_LDR;
          end
        end
      end
      ST_LDR_HIGH: begin
        if (fall) begin
          if (s_q.cyc_cnt >= s_q.cfg.leader_cycle_min &&
              s_q.cyc_cnt <= s_q.cfg.leader_cycle_max) begin
            s_d.st = ST_DATA;
            set.leader_det = 1'b1;
            set.leader_irq = s_q.cfg.leader_irq_enable;
          end else begin
            s_d.st = ST_LDR_LOW;
          end
        end else if (tick && s_q.cyc_cnt == `CNT_SAT) begin
          s_d.st = ST_WAIT_LDR;
        end
      end
      ST_DATA: begin
        if (fall) begin
          set.edge_irq = s_q.cfg.falling_edge_irq_enable;
          // Each fall closes one interval; phase mode assumes
          // the frame opens with a one pair
          if (!s_q.cfg.phase_method_enable) begin
            nbits = 2'h1;
            bit0 = s_q.cyc_cnt >= {1'b0, s_q.cfg.thresh_low};
          end else if (s_q.cyc_cnt < {1'b0, s_q.cfg.thresh_low}) begin
            nbits = 2'h1; // 1T keeps the previous value
            bit0 = s_q.prev_bit;
          end else if (s_q.cyc_cnt < {1'b0, s_q.cfg.thresh_high}) begin
            nbits = s_q.prev_bit ? 2'h1 : 2'h2; // 1.5T
            bit0 = ~s_q.prev_bit;
            bit1 = 1'b1;
          end else begin
            nbits = 2'h2; // 2T gives zero then one
            bit0 = 1'b0;
            bit1 = 1'b1;
          end
          // Bits past the buffer width are dropped, not wrapped
          if (nbits != 2'h0 && s_q.bit_cnt < `MAX_FRAME_BITS) begin
            s_d.shreg[s_q.bit_cnt] = bit0;
            s_d.bit_cnt = s_q.bit_cnt + 7'h01;
          end
          if (nbits == 2'h2 && s_d.bit_cnt < `MAX_FRAME_BITS) begin
            s_d.shreg[s_d.bit_cnt] = bit1;
            s_d.bit_cnt = s_d.bit_cnt + 7'h01;
          end
          if (nbits != 2'h0) begin
            s_d.prev_bit = (nbits == 2'h2) ? bit1 : bit0;
          end
        end else if (tick) begin
          // Earliest condition wins; timeout first on a tie
          // Counts are ticks since the last fall, before this one
          timeout = s_q.cfg.max_bit_cycle_limit != 8'h00 &&
                    s_q.cyc_cnt >= s_q.cfg.max_bit_cycle_limit;
          excess = s_q.cfg.excess_low_limit != 8'h00 && !new_filt &&
                   s_q.low_cnt > s_q.cfg.excess_low_limit;
          any_end = s_q.cfg.expected_bits_a != 7'h00 ||
                    s_q.cfg.expected_bits_b != 7'h00 ||
                    s_q.cfg.expected_bits_c != 7'h00;
          cnt_ok = s_q.bit_cnt == s_q.cfg.expected_bits_a ||
                   s_q.bit_cnt == s_q.cfg.expected_bits_b ||
                   s_q.bit_cnt == s_q.cfg.expected_bits_c;
          if (timeout) begin
            if (!any_end || cnt_ok) begin
              finish = 1'b1;
              set.max_cycle_flag = 1'b1;
            end else begin
              s_d.st = ST_WAIT_LDR;
            end
          end else if (excess) begin
            finish = 1'b1;
            set.excess_low_flag = 1'b1;
          end
        end
        if (finish) begin
          // Buffers load whole, so a partial frame never shows
          s_d.rx_buf = s_q.shreg;
          s_d.last_cnt = s_q.bit_cnt;
          set.done = 1'b1;
          s_d.st = ST_WAIT_LDR;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase

    // Disabling aborts and drops the partial frame
    if (!s_q.cfg.receive_enable_bit) begin
      s_d.st = ST_IDLE;
      s_d.shreg = '0;
      s_d.bit_cnt = 7'h00;
      // Events of the disabling cycle belong to the lost frame
      set = '0;
    end

    // Hardware set wins over software clear
    s_d.flags = (s_q.flags & ~clr) | set;
    s_d.irq = s_d.flags.leader_irq | s_d.flags.edge_irq |
              s_d.flags.max_cycle_flag | s_d.flags.excess_low_flag |
              s_d.flags.done;
  end

  // State register; idle line assumed high after reset
  // A raw sample reset low would fake a fall at the first tick
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= '0;
      s_q.waitreq <= 1'b1;
      s_q.st <= ST_IDLE;
      s_q.raw <= 1'b1;
      s_q.filt <= 1'b1;
      s_q.prev_bit <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flops
  assign avs_readdata_o = s_q.rdata;
  assign avs_waitrequest_o = s_q.waitreq;
  assign irq_o = s_q.irq;

endmodule : remote_receiver

// *** hdl/remote_receiver_cfg.svh ***
// Offsets, field positions and limits of the pulse receiver
`ifndef REMOTE_RECEIVER_CFG_SVH
`define REMOTE_RECEIVER_CFG_SVH

// Register byte offsets
`define OFS_ENABLE 6'h00
`define OFS_LEADER 6'h04
`define OFS_RXCTRL 6'h08
`define OFS_THRESH 6'h0c
`define OFS_INPUT 6'h10
`define OFS_ENDBITS 6'h14
`define OFS_STATUS 6'h18
`define OFS_BUF_A 6'h1c
`define OFS_BUF_B 6'h20
`define OFS_BUF_C 6'h24

// Enable register fields
`define EN_RX_BIT 0
`define EN_CLKSEL_BIT 1

// Receive control register fields
`define RC_DMAX_LSB 0
`define RC_LL_LSB 8
`define RC_LIEN_BIT 16
`define RC_EDIEN_BIT 17
`define RC_LDOPT_BIT 18
`define RC_PHASE_BIT 19

// Input configuration fields
`define IN_INVERT_BIT 8

// Status register fields
`define ST_LDR_DET_BIT 8
`define ST_LDR_IRQ_BIT 9
`define ST_EDGE_IRQ_BIT 10
`define ST_MAX_BIT 11
`define ST_LOW_BIT 12
`define ST_DONE_BIT 13
`define ST_BUSY_BIT 14

// Frame limits
`define MAX_FRAME_BITS 7'h48
`define CNT_SAT 8'hff

`endif

// *** hdl/remote_receiver_pkg.sv ***
// Types shared by the pulse receiver and its bench
package remote_receiver_pkg;

  // Avalon-MM request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [31:0] writedata;
  } avalon_req_t;

  // Receiver sequencing states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_WAIT_LDR = 5'b00010,
    ST_LDR_LOW = 5'b00100,
    ST_LDR_HIGH = 5'b01000,
    ST_DATA = 5'b10000
  } rx_state_t;

  // Software configuration
  typedef struct packed {
    logic receive_enable_bit;
    logic sample_clock_select;
    logic [7:0] leader_cycle_max;
    logic [7:0] leader_cycle_min;
    logic [7:0] leader_low_max;
    logic [7:0] leader_low_min;
    logic [7:0] max_bit_cycle_limit;
    logic [7:0] excess_low_limit;
    logic leader_irq_enable;
    logic falling_edge_irq_enable;
    logic leader_optional;
    logic phase_method_enable;
    logic [6:0] thresh_high;
    logic [6:0] thresh_low;
    logic input_invert;
    logic [3:0] noise_filter_cycles;
    logic [6:0] expected_bits_a;
    logic [6:0] expected_bits_b;
    logic [6:0] expected_bits_c;
  } rx_cfg_t;

  // Sticky event flags
  typedef struct packed {
    logic leader_det;
    logic leader_irq;
    logic edge_irq;
    logic max_cycle_flag;
    logic excess_low_flag;
    logic done;
  } rx_flags_t;

  // Whole module state
  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic irq;
    rx_cfg_t cfg;
    rx_state_t st;
    logic raw;
    logic filt;
    logic [3:0] flt_cnt;
    logic [7:0] low_cnt;
    logic [7:0] cyc_cnt;
    logic prev_bit;
    logic [71:0] shreg;
    logic [6:0] bit_cnt;
    logic [6:0] last_cnt;
    logic [71:0] rx_buf;
    rx_flags_t flags;
  } rx_state_all_t;

endpackage : remote_receiver_pkg

// *** sim/remote_pulse_source.sv ***
// Far-end pulse source: sample ticks and demodulated remote line
`timescale 1ns/1ps

module remote_pulse_source (
  // Clock and choices from the bench
  input wire logic clk_i,
  input wire logic sel_i,
  input wire logic invert_i,
  // Sample ticks and line
  output logic lf_tick_o = 1'b0,
  output logic timer_tick_o = 1'b0,
  output logic rx_o
);
  int unsigned div_q = 0;
  logic lvl_q = 1'b1;

  // Unrelated tick rates, so a wrong select distorts every width
  always @(posedge clk_i) begin
    div_q <= div_q + 1;
    lf_tick_o <= div_q % 4 == 0;
    timer_tick_o <= div_q % 6 == 3;
  end

  // Idle high; sent inverted when the bench asks for it
  assign rx_o = lvl_q ^ invert_i;

  // Hold a level for n selected ticks, moving just after a tick
  task automatic hold(input logic level, input int n);
    lvl_q <= level;
    repeat (n) begin
      do @(posedge clk_i); while (!(sel_i ? timer_tick_o : lf_tick_o));
    end
  endtask : hold

endmodule : remote_pulse_source

// *** sim/remote_receiver_monitor.sv ***
// Checker of bus handshake and interrupt timing of the pulse receiver
`timescale 1ns/1ps
`include "remote_receiver_cfg.svh"

module remote_receiver_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register bus
  input wire remote_receiver_pkg::avalon_req_t avs_req_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Ticks, line and interrupt
  input wire logic lf_tick_i,
  input wire logic timer_output_clock_i,
  input wire logic remote_rx_i,
  input wire logic irq_o
);
  import remote_receiver_pkg::*;
  logic wt;
  logic req;
  logic acc;
  logic st_wr;
  logic en_q;

  // Request, accepted write and flag-clearing write
  assign wt = avs_waitrequest_o;
  assign req = avs_req_i.read || avs_req_i.write;
  assign acc = avs_req_i.write && !wt;
  assign st_wr = acc && avs_req_i.address == `OFS_STATUS &&
    |avs_req_i.writedata[13:8];

  // Shadow of receive enable; only accepted writes move it
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      en_q <= 1'b0;
    end else if (acc && avs_req_i.address == `OFS_ENABLE) begin
      en_q <= avs_req_i.writedata[`EN_RX_BIT];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_ans; req && wt |=> !wt ##1 wt; endproperty
  a_ans: assert property (p_ans) else $error("bus answer late");
  property p_idle; !req && wt |=> wt; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_cause; !wt |-> $past(req && wt); endproperty
  a_cause: assert property (p_cause) else $error("stray answer");
  property p_rdh; !(avs_req_i.read && wt) |=> $stable(avs_readdata_o);
  endproperty
  a_rdh: assert property (p_rdh) else $error("read data moved");
  property p_unm; avs_req_i.read && wt && avs_req_i.address > `OFS_BUF_C
    |=> avs_readdata_o == '0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_irqr;
    $rose(irq_o) |-> $past(lf_tick_i || timer_output_clock_i);
  endproperty
  a_irqr: assert property (p_irqr) else $error("irq without tick");
  property p_irqf; $fell(irq_o) |-> $past(st_wr); endproperty
  a_irqf: assert property (p_irqf) else $error("irq fell alone");
  property p_off; !en_q && $past(!en_q, 4) |-> !$rose(irq_o); endproperty
  a_off: assert property (p_off) else $error("irq while off");

endmodule : remote_receiver_monitor

bind remote_receiver remote_receiver_monitor mon_u (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .avs_req_i(avs_req_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .lf_tick_i(lf_tick_i), .timer_output_clock_i(timer_output_clock_i),
  .remote_rx_i(remote_rx_i), .irq_o(irq_o)
);

// *** sim/tb_top.sv ***
// Self-checking bench for the pulse receiver
`timescale 1ns/1ps
`include "remote_receiver_cfg.svh"

module tb_top;
  import remote_receiver_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  avalon_req_t req = '0;
  logic [31:0] rdata;
  logic wt;
  logic irq;
  logic lf_tick;
  logic tm_tick;
  logic rx;
  logic sel = 1'b0;
  logic inv = 1'b0;
  logic [31:0] q;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;

  // Clock of 40 MHz
  always #12.5 clk_i = ~clk_i;

  remote_receiver dut_u (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .avs_req_i(req),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wt),
    .lf_tick_i(lf_tick), .timer_output_clock_i(tm_tick),
    .remote_rx_i(rx), .irq_o(irq)
  );

  remote_pulse_source src_u (
    .clk_i(clk_i), .sel_i(sel), .invert_i(inv),
    .lf_tick_o(lf_tick), .timer_tick_o(tm_tick), .rx_o(rx)
  );

  // Counts, verdict and end of run
  task automatic results();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // Compare and count
  task automatic check(input string w, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", w, exp, got);
    end
  endtask : check

  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a,
    input logic [31:0] d);
    req <= '{read: !wr, write: wr, address: a, writedata: d};
    do begin
      @(posedge clk_i);
    end while (wt !== 1'b0);
    q = rdata;
    req <= '0;
    @(posedge clk_i);
  endtask : bus

  // Masked register read against an expected value
  task automatic rchk(input logic [5:0] a, input logic [31:0] m, e,
    input string w);
    bus(1'b0, a, '0);
    check(w, q & m, e);
  endtask : rchk

  // Clear sticky flags; the interrupt drops with them at the same edge
  task automatic clr();
    bus(1'b1, `OFS_STATUS, 32'h0000_3f00);
    @(negedge clk_i);
    check("irq_clr", {31'h0, irq}, 32'h0);
    @(posedge clk_i);
  endtask : clr

  // Leader 12+12 ticks, bit periods 6 for one and 5 for zero
  task automatic frame(input logic [7:0] b, input int n, input int tail);
    src_u.hold(1'b0, 12);
    src_u.hold(1'b1, 12);
    for (int i = 0; i < n; i++) begin
      src_u.hold(1'b0, 2);
      src_u.hold(1'b1, b[i] ? 4 : 3);
    end
    src_u.hold(1'b0, tail);
    src_u.hold(1'b1, 40);
  endtask : frame

  // Hang guard, far beyond the expected run
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  initial begin
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    rchk(`OFS_STATUS, '1, '0, "status_rst");
    rchk(`OFS_ENDBITS, '1, '0, "endbits_rst");
    rchk(6'h3c, '1, '0, "unmapped");
    // Leader windows, limits, threshold, filter of 2
    bus(1'b1, `OFS_LEADER, 32'h2814_1008);
    bus(1'b1, `OFS_RXCTRL, 32'h0003_0a14);
    bus(1'b1, `OFS_THRESH, 32'h0000_0a06);
    bus(1'b1, `OFS_INPUT, 32'h0000_0002);
    bus(1'b1, `OFS_ENABLE, 32'h0000_0001);
    frame(8'h0d, 4, 2);
    check("irq", {31'h0, irq}, 32'h1);
    rchk(`OFS_STATUS, '1, 32'h0000_2f04, "status");
    rchk(`OFS_BUF_A, '1, 32'h0000_000d, "buf_a");
    rchk(`OFS_BUF_B, '1, '0, "buf_b");
    clr();
    // Long low after the last fall
    frame(8'h01, 2, 30);
    rchk(`OFS_STATUS, '1, 32'h0000_3702, "status_low");
    rchk(`OFS_BUF_A, '1, 32'h0000_0001, "buf_low");
    clr();
    // Expected counts 5 and 4: three bits refused, four taken
    bus(1'b1, `OFS_ENDBITS, 32'h0000_0405);
    frame(8'h05, 3, 2);
    rchk(`OFS_STATUS, 32'h0000_2800, '0, "status_cnt");
    rchk(`OFS_BUF_A, '1, 32'h0000_0001, "buf_cnt");
    clr();
    frame(8'h0a, 4, 2);
    rchk(`OFS_STATUS, '1, 32'h0000_2f04, "status_cnt4");
    rchk(`OFS_BUF_A, '1, 32'h0000_000a, "buf_cnt4");
    bus(1'b1, `OFS_ENDBITS, '0);
    clr();
    // Enable dropped in mid-frame
    fork
      frame(8'h0f, 4, 2);
      begin
        repeat (150) @(posedge clk_i);
        bus(1'b1, `OFS_ENABLE, '0);
      end
    join
    rchk(`OFS_STATUS, 32'h0000_2800, '0, "status_abort");
    rchk(`OFS_BUF_A, '1, 32'h0000_000a, "buf_abort");
    clr();
    // Inverted line timed by the timer tick
    bus(1'b1, `OFS_INPUT, 32'h0000_0102);
    inv <= 1'b1;
    sel <= 1'b1;
    bus(1'b1, `OFS_ENABLE, 32'h0000_0003);
    frame(8'h0b, 4, 2);
    rchk(`OFS_STATUS, '1, 32'h0000_2f04, "status_inv");
    rchk(`OFS_BUF_A, '1, 32'h0000_000b, "buf_inv");
    clr();
    // Phase method: intervals 1T,1T,1.5T,1.5T give 1,1,0,1,1
    bus(1'b1, `OFS_RXCTRL, 32'h000b_0a14);
    frame(8'h0c, 4, 2);
    rchk(`OFS_STATUS, '1, 32'h0000_2f05, "status_phase");
    rchk(`OFS_BUF_A, '1, 32'h0000_001b, "buf_phase");
    clr();
    // No leader: leader fall opens bit 0, no leader flags
    bus(1'b1, `OFS_LEADER, 32'h0000_1008);
    bus(1'b1, `OFS_RXCTRL, 32'h0003_201e);
    frame(8'h05, 3, 2);
    rchk(`OFS_STATUS, '1, 32'h0000_2c04, "status_nold");
    rchk(`OFS_BUF_A, '1, 32'h0000_000b, "buf_nold");
    clr();
    // Leader low under the window, optional: data from its fall
    bus(1'b1, `OFS_LEADER, 32'h2814_100d);
    bus(1'b1, `OFS_RXCTRL, 32'h0007_201e);
    frame(8'h02, 3, 2);
    rchk(`OFS_STATUS, '1, 32'h0000_2c04, "status_opt");
    rchk(`OFS_BUF_A, '1, 32'h0000_0005, "buf_opt");
    results();
  end

endmodule : tb_top
